// *** tas_consts.vh ***
// constants for the trigger arm sequencer
// included by bare name; definitions only
`ifndef TAS_CONSTS_VH
`define TAS_CONSTS_VH
`define TAS_ARM_ARMED    1'h0
`define TAS_ARM_SELF     1'h1
`define TAS_TRIG_CONT    2'h0
`define TAS_TRIG_TRIG    2'h1
`define TAS_TRIG_GATED   2'h2
`define TAS_POL_NEG      2'h0
`define TAS_POL_POS      2'h1
`define TAS_POL_EITHER   2'h2
`define TAS_OP_SYNC      1'h0
`define TAS_OP_ASYNC     1'h1
`define TAS_PERIOD_W     32
`define TAS_PERIOD_RST   32'h0ee6b280
`define TAS_ST_IDLE      2'h0
`define TAS_ST_WAITEN    2'h1
`define TAS_ST_WAITTRIG  2'h2
`define TAS_ST_RUN       2'h3
`endif

// *** tas_edge_qual.v ***
// input qualifier: two-flop synchroniser, polarity-aware edge detection
// assumes pin is asynchronous to clk; one pulse per qualifying edge
`timescale 1ns/10ps
`default_nettype none
`include "tas_consts.vh"
module tas_edge_qual (
	// clock and reset
	input  wire       ref_clk,
	input  wire       nrst,
	// pin and settings
	input  wire       pin,
	input  wire [1:0] polarity,
	input  wire       opAsync,
	input  wire       syncStrobe,
	// results
	output reg        edgePulse,
	output reg        rise,
	output reg        fall,
	output reg        level
);
	reg syncA;
	reg syncB;
	reg prev;
	reg held;
	wire cur;

	// sync mode: sample only on strobe; async: every cycle
	assign cur = (opAsync == `TAS_OP_ASYNC) ? syncB : held;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			syncA     <= 1'h0;
			syncB     <= 1'h0;
			held      <= 1'h0;
			prev      <= 1'h0;
			edgePulse <= 1'h0;
			rise      <= 1'h0;
			fall      <= 1'h0;
			level     <= 1'h0;
		end else begin
			syncA <= pin;
			syncB <= syncA;
			if (syncStrobe) begin
				held <= syncB;
			end
			prev  <= cur;
			rise  <= cur & ~prev;
			fall  <= ~cur & prev;
			level <= (polarity == `TAS_POL_NEG) ? ~cur : cur;
			case (polarity)
			`TAS_POL_NEG:    edgePulse <= ~cur & prev;
			`TAS_POL_POS:    edgePulse <= cur & ~prev;
			default:         edgePulse <= cur ^ prev;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tas_seq_chk.sv ***
// assertions on the sequencer ports
// bound onto every tas_sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tas_consts.vh"
module tas_seq_chk (
	// clock, reset, pin
	input wire       ref_clk, nrst, trigPin,
	// settings and commands
	input wire       armMode, opAsync, runCmd, stopCmd,
	input wire       forceTrig, forceEvent, forceEnable,
	input wire [1:0] trigMode, polarity,
	// results
	input wire       genActive, advanceEvent, trigSeen,
	input wire [1:0] seqState
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence sGo;
		runCmd && !stopCmd && seqState == `TAS_ST_IDLE;
	endsequence
	sequence sTrig;
		forceTrig && !stopCmd && seqState == `TAS_ST_WAITTRIG;
	endsequence
	a_stop_idle: assert property (stopCmd |=>
		seqState == `TAS_ST_IDLE && !genActive) else $error("stop ignored");
	a_self_cont: assert property (sGo ##0 armMode && !trigMode |=>
		seqState == `TAS_ST_RUN && genActive) else $error("no start");
	a_armed_hold: assert property (sGo ##0 !armMode |=>
		seqState == `TAS_ST_WAITEN && !genActive) else $error("no hold");
	a_force_enable: assert property (forceEnable && !stopCmd &&
		seqState == `TAS_ST_WAITEN && trigMode == `TAS_TRIG_TRIG
		|=> seqState == `TAS_ST_WAITTRIG) else $error("enable lost");
	a_force_trig: assert property (sTrig |=>
		seqState == `TAS_ST_RUN && genActive && trigSeen)
		else $error("trigger lost");
	a_wait_quiet: assert property (seqState != `TAS_ST_RUN |->
		!genActive) else $error("active while waiting");
	a_event_adv: assert property (forceEvent && genActive && !stopCmd
		|=> advanceEvent) else $error("event lost");
	a_pin_edge: assert property ((polarity == `TAS_POL_NEG ?
		$fell(trigPin) : $rose(trigPin)) && opAsync && trigMode ==
		`TAS_TRIG_TRIG && seqState == `TAS_ST_WAITTRIG |-> ##[2:6] trigSeen)
		else $error("pin edge lost");
	a_gate_pause: assert property ($fell(trigPin) && opAsync &&
		trigMode == `TAS_TRIG_GATED && polarity == `TAS_POL_POS &&
		genActive |-> ##[2:7] !genActive) else $error("no pause");
endmodule
bind tas_sequencer tas_seq_chk tas_seq_chk_inst (.ref_clk, .nrst, .trigPin,
	.armMode, .opAsync, .runCmd, .stopCmd, .forceTrig, .forceEvent,
	.forceEnable, .trigMode, .polarity, .genActive, .advanceEvent,
	.trigSeen, .seqState);
`default_nettype wire

// *** tas_sequencer.v ***
// trigger arm sequencer: arm mode, trigger mode, gating, internal trigger
// assumes software controls arrive as one-cycle pulses on ref_clk
// assumes trigger and event pins are asynchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "tas_consts.vh"
module tas_sequencer #(
	parameter PERIOD_W = `TAS_PERIOD_W
) (
	// clock and reset
	input  wire                ref_clk,
	input  wire                nrst,
	// pins
	input  wire                trigPin,
	input  wire                eventPin,
	// configuration
	input  wire                armMode,
	input  wire [1:0]          trigMode,
	input  wire [1:0]          polarity,
	input  wire                opAsync,
	input  wire                intTrigOn,
	input  wire [PERIOD_W-1:0] intPeriod,
	input  wire                syncStrobe,
	// software commands
	input  wire                runCmd,
	input  wire                stopCmd,
	input  wire                forceTrig,
	input  wire                forceEvent,
	input  wire                forceEnable,
	// results
	output reg                 genActive,
	output reg                 advanceEvent,
	output reg                 trigSeen,
	output reg  [1:0]          seqState
);
	// qualified pin pulses
	wire trigEdge;
	wire trigRise;
	wire trigFall;
	wire evEdge;
	wire enablePulse;
	wire anyTrig;
	wire [PERIOD_W-1:0] intNext;
	// internal state
	reg  [PERIOD_W-1:0] intCount;
	reg                 intPulse;
	reg  [1:0]          next_state;
	reg                 next_active;
	reg                 gateOpen;
	reg                 running;

	// sequencer states
	localparam [1:0] ST_IDLE     = `TAS_ST_IDLE;
	localparam [1:0] ST_WAITEN   = `TAS_ST_WAITEN;
	localparam [1:0] ST_WAITTRIG = `TAS_ST_WAITTRIG;
	localparam [1:0] ST_RUN      = `TAS_ST_RUN;

	// state and activity once arming is done
	function [2:0] armedNext(input [1:0] mode);
		if (mode == `TAS_TRIG_CONT)
			armedNext = {ST_RUN, 1'h1};
		else
			armedNext = {ST_WAITTRIG, 1'h0};
	endfunction

	// gate opens on a pin rising edge or a forced trigger
	function gateRise(input rise, input forced);
		gateRise = rise | forced;
	endfunction

	// both qualifiers share polarity and operation settings
	tas_edge_qual trigQual (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.pin        (trigPin),
		.polarity   (polarity),
		.opAsync    (opAsync),
		.syncStrobe (syncStrobe),
		.edgePulse  (trigEdge),
		.rise       (trigRise),
		.fall       (trigFall),
		.level      ()
	);

	tas_edge_qual eventQual (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.pin        (eventPin),
		.polarity   (polarity),
		.opAsync    (opAsync),
		.syncStrobe (syncStrobe),
		.edgePulse  (evEdge),
		.rise       (),
		.fall       (),
		.level      ()
	);

	// internal periodic trigger, period in clock cycles
	// a period of zero or one fires on every cycle
	assign intNext = intCount + {{(PERIOD_W-1){1'b0}}, 1'b1};

	// counter runs only while out of idle
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			intCount <= {PERIOD_W{1'b0}};
			intPulse <= 1'h0;
		end else if (!intTrigOn || !running) begin
			intCount <= {PERIOD_W{1'b0}};
			intPulse <= 1'h0;
		end else if (intNext >= intPeriod) begin
			intCount <= {PERIOD_W{1'b0}};
			intPulse <= 1'h1;
		end else begin
			intCount <= intNext;
			intPulse <= 1'h0;
		end
	end

	// every trigger source merges here
	assign anyTrig     = trigEdge | forceTrig | intPulse;
	assign enablePulse = evEdge | forceEnable;

	// gate tracking: rising opens, falling closes; forced trigger opens
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gateOpen <= 1'h0;
		end else if (gateRise(trigRise, forceTrig)) begin
			gateOpen <= 1'h1;
		end else if (trigFall) begin
			gateOpen <= 1'h0;
		end
	end

	// next state; stop overrides every other request
	always @* begin
		next_state  = seqState;
		next_active = genActive;
		case (seqState)
		ST_IDLE: begin
			next_active = 1'h0;
			if (runCmd) begin
				if (armMode == `TAS_ARM_ARMED)
					next_state = ST_WAITEN;
				else
					{next_state, next_active} = armedNext(trigMode);
			end
		end
		ST_WAITEN: begin
			if (enablePulse)
				{next_state, next_active} = armedNext(trigMode);
		end
		ST_WAITTRIG: begin
			if (trigMode == `TAS_TRIG_GATED) begin
				if (gateRise(trigRise, forceTrig)) begin
					next_state  = ST_RUN;
					next_active = 1'h1;
				end
			end else if (anyTrig) begin
				next_state  = ST_RUN;
				next_active = 1'h1;
			end
		end
		ST_RUN: begin
			if (trigMode == `TAS_TRIG_GATED) begin
				if (trigFall)
					next_active = 1'h0;
				else if (gateRise(trigRise, forceTrig))
					next_active = 1'h1;
				else
					next_active = gateOpen;
			end else
				next_active = 1'h1;
		end
		default: begin
			next_state  = ST_IDLE;
			next_active = 1'h0;
		end
		endcase
		if (stopCmd) begin
			next_state  = ST_IDLE;
			next_active = 1'h0;
		end
	end

	// state and level outputs
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			seqState  <= ST_IDLE;
			genActive <= 1'h0;
			running   <= 1'h0;
		end else begin
			seqState  <= next_state;
			genActive <= next_active;
			running   <= (next_state != ST_IDLE);
		end
	end

	// one-cycle result pulses
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			advanceEvent <= 1'h0;
			trigSeen     <= 1'h0;
		end else begin
			advanceEvent <= genActive & (evEdge | forceEvent);
			trigSeen     <= anyTrig;
		end
	end
endmodule
`default_nettype wire

// *** tas_src.sv ***
// source model for the trigger and event pins
// pins are levels, changed at any phase of ref_clk
`timescale 1ns/10ps
`default_nettype none
module tas_src (
	// source pins
	output logic trigPin = 1'h0,
	output logic eventPin = 1'h0
);
	// new levels after d ns, prompt or slow, off the clock grid
	task drive(input logic t, input logic e, input realtime d);
		#d;
		{trigPin, eventPin} = {t, e};
	endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the trigger arm sequencer
// commands from tasks; pins from the source model
`timescale 1ns/10ps
`default_nettype none
`include "tas_consts.vh"
`define CHK(n,e,a) begin checksDone++; if ((a) !== (e)) begin errorCnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
	logic        ref_clk = 0, nrst = 0, armMode, opAsync, intTrigOn, syncStrobe;
	logic [4:0]  cmd = 5'h0;
	logic [1:0]  trigMode, polarity;
	logic [31:0] intPeriod;
	wire         trigPin, eventPin, genActive, advanceEvent, trigSeen;
	wire  [1:0]  seqState;
	int          errorCnt = 0, checksDone = 0, cyc = 0;
	tas_sequencer tas_sequencer_inst (.ref_clk, .nrst, .trigPin, .eventPin,
		.armMode, .trigMode, .polarity, .opAsync, .intTrigOn, .intPeriod,
		.syncStrobe, .runCmd(cmd[4]), .stopCmd(cmd[3]), .forceTrig(cmd[2]),
		.forceEvent(cmd[1]), .forceEnable(cmd[0]), .genActive, .advanceEvent,
		.trigSeen, .seqState);
	tas_src tas_src_inst (.trigPin, .eventPin);
	initial forever #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (++cyc > 3000) begin
		errorCnt++;
		stopTest;
	end
	task stopTest;
		if (errorCnt == 0 && checksDone > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task tick;
		@(posedge ref_clk) #1;
	endtask
	// run, stop, trigger, event, enable
	task send(input logic [4:0] c);
		tick;
		cmd = c;
		tick;
		cmd = 5'h0;
	endtask
	task waitFor(input logic [2:0] e, input string n);
		int i;
		for (i = 0; i < 20 && {seqState, genActive} !== e; i++) tick;
		`CHK(n, e, {seqState, genActive})
	endtask
	task cfg(input logic a, input logic [1:0] t, p, input logic o);
		{armMode, trigMode, polarity, opAsync} = {a, t, p, o};
	endtask
	task settle(input logic t);
		syncStrobe = 1'h1;
		tas_src_inst.drive(t, 1'h0, 0.9);
		repeat (8) tick;
		syncStrobe = 1'h0;
	endtask
	initial begin
		{armMode, opAsync, intTrigOn, syncStrobe} = 4'h0;
		{trigMode, polarity} = 4'h1;
		intPeriod = 32'h8;
		repeat (3) tick;
		nrst = 1;
		`CHK("reset", 3'h0, {seqState, genActive})
		cfg(`TAS_ARM_SELF, `TAS_TRIG_CONT, `TAS_POL_POS, `TAS_OP_ASYNC);
		send(5'h10); waitFor(3'h7, "cont");
		send(5'h08); waitFor(3'h0, "stop");
		cfg(`TAS_ARM_ARMED, `TAS_TRIG_TRIG, `TAS_POL_POS, `TAS_OP_ASYNC);
		send(5'h10); waitFor(3'h2, "armed");
		send(5'h04); `CHK("early trig", 3'h2, {seqState, genActive})
		`CHK("trig seen", 1'h1, trigSeen)
		send(5'h01); waitFor(3'h4, "enable");
		send(5'h04); waitFor(3'h7, "forced");
		send(5'h02); `CHK("event", 1'h1, advanceEvent)
		send(5'h08); send(5'h10);
		tas_src_inst.drive(1'h0, 1'h1, 0.7); waitFor(3'h4, "ev pin");
		`CHK("idle event", 1'h0, advanceEvent)
		tas_src_inst.drive(1'h1, 1'h0, 2.3); waitFor(3'h7, "tr pin");
		send(5'h08);
		for (int p = 0; p < 3; p++) begin
			cfg(`TAS_ARM_SELF, `TAS_TRIG_TRIG, p[1:0], `TAS_OP_ASYNC);
			settle(p == 0);
			send(5'h10); waitFor(3'h4, "pol wait");
			tas_src_inst.drive(p != 0, 1'h0, 1.9); waitFor(3'h7, "pol");
			send(5'h08);
		end
		cfg(`TAS_ARM_SELF, `TAS_TRIG_GATED, `TAS_POL_POS, `TAS_OP_ASYNC);
		settle(1'h0); send(5'h10);
		tas_src_inst.drive(1'h1, 1'h0, 1.2); waitFor(3'h7, "gate on");
		tas_src_inst.drive(1'h0, 1'h0, 0.4); waitFor(3'h6, "gate off");
		tas_src_inst.drive(1'h1, 1'h0, 2.6); waitFor(3'h7, "gate on2");
		send(5'h08);
		cfg(`TAS_ARM_SELF, `TAS_TRIG_TRIG, `TAS_POL_POS, `TAS_OP_SYNC);
		settle(1'h0); send(5'h10);
		tas_src_inst.drive(1'h1, 1'h0, 1.4);
		repeat (10) tick;
		`CHK("sync hold", 3'h4, {seqState, genActive})
		syncStrobe = 1'h1; waitFor(3'h7, "sync");
		syncStrobe = 1'h0; send(5'h08);
		opAsync = 1'h1; intTrigOn = 1'h1;
		send(5'h10);
		repeat (8) tick;
		`CHK("int early", 3'h4, {seqState, genActive})
		tick;
		`CHK("internal", 3'h7, {seqState, genActive})
		send(5'h08); intTrigOn = 1'h0;
		stopTest;
	end
endmodule
`default_nettype wire
